/* File: arl_pkg.sv */
// arl_pkg: constants and register map of the alarm relay latch block
package arl_pkg;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int RETURN_S = 30;
  localparam int RETURN_TICKS = RETURN_S * 1000 / TICK_MS;
  localparam int MSG_S = 8;
  localparam int MSG_TICKS = MSG_S * 1000 / TICK_MS;
  localparam int MSG_ON_TICKS = 5;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LATCH = 8'h04;
  localparam logic [7:0] A_NC = 8'h08;
  localparam logic [7:0] A_ACKEN = 8'h0C;
  localparam logic [7:0] A_AND = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_DISP = 8'h18;
  // per-alarm groups, selected by address bits 7:5, alarm by bits 4:2
  localparam logic [2:0] G_MAP = 3'h1;
  localparam logic [2:0] G_TRIP = 3'h2;
  localparam logic [2:0] G_RST = 3'h3;
  // control register fields
  localparam int F_MODE = 0;
  localparam int F_DFLT = 2;
  localparam int F_DEC = 4;
  localparam int F_REM = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] RST_CTRL = 9'h000;
  // status fields
  localparam int F_ACT = 8;
  localparam int F_COND = 16;
  // measurement modes
  localparam logic [1:0] MODE_RATE = 2'h0;
  localparam logic [1:0] MODE_TOTAL = 2'h1;
  localparam logic [1:0] MODE_BOTH = 2'h2;
endpackage : arl_pkg

/* File: arl_alarm_unit.sv */
// arl_alarm_unit: one alarm's clear band, trip delay and reset delay
`timescale 1ns/10ps
`default_nettype none
module arl_alarm_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  // value comparison flags
  input wire logic enter,
  input wire logic leave,
  // delays in ticks
  input wire logic [15:0] trip_lim,
  input wire logic [15:0] rst_lim,
  // state
  output logic cond,
  output logic act
);
  logic [15:0] cnt;
  wire logic differ;
  wire logic [15:0] lim;
  assign differ = cond ^ act;
  assign lim = cond ? trip_lim : rst_lim;

  // condition sets at setpoint, clears only beyond the band
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cond <= 1'b0;
    else if (enter) cond <= 1'b1;
    else if (leave) cond <= 1'b0;
  end

  // any flip back to agreement restarts the delay from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      act <= 1'b0;
    end else if (!differ) begin
      cnt <= 16'h0000;
    end else if (cnt >= lim) begin
      act <= cond;
      cnt <= 16'h0000;
    end else if (tick) begin
      cnt <= cnt + 16'h0001;
    end
  end

  property p_trip_held;
    @(posedge pclk) disable iff (!presetn) $rose(act) |-> $past(cond) && cond;
  endproperty
  a_trip_held: assert property (p_trip_held) else $error("act rose without condition");
  property p_rst_held;
    @(posedge pclk) disable iff (!presetn) $fell(act) |-> !$past(cond) && !cond;
  endproperty
  a_rst_held: assert property (p_rst_held) else $error("act fell with condition");
  property p_band;
    @(posedge pclk) disable iff (!presetn) cond && !leave |=> cond;
  endproperty
  a_band: assert property (p_band) else $error("cleared inside band");
  property p_restart;
    @(posedge pclk) disable iff (!presetn) (cond == act) |=> cnt == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");
endmodule : arl_alarm_unit
`default_nettype wire

/* File: arl_relay_ctrl.sv */
// arl_relay_ctrl: alarm to relay logic, annunciators and display select
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module arl_relay_ctrl #(
  parameter int NA = 8,
  parameter int NR = 7,
  parameter int DIGITS = 5,
  parameter int TICK_CYC = arl_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // alarm comparison flags, same clock
  input wire logic [NA-1:0] alarm_enter,
  input wire logic [NA-1:0] alarm_leave,
  // operator pins
  input wire logic ack_btn_n,
  input wire logic remote_in,
  input wire logic toggle_btn_n,
  // outputs
  output logic [NR-1:0] relay_drive,
  output logic [NA-1:0] annunciator,
  output logic show_total,
  output logic msg_flash,
  output logic [2:0] dec_places
);
  localparam logic [8:0] RET_LIM = 9'(arl_pkg::RETURN_TICKS - 1);
  localparam logic [8:0] MSG_LIM = 9'(arl_pkg::MSG_TICKS - 1);
  localparam logic [8:0] MSG_ON = 9'(arl_pkg::MSG_ON_TICKS);
  localparam logic [2:0] DEC_MAX = 3'(DIGITS - 1);
  localparam logic [31:0] TICK_LIM = 32'(TICK_CYC - 1);

  // configuration registers
  logic [arl_pkg::CTRL_W-1:0] ctrl;
  logic [NR-1:0] latch_en;
  logic [NR-1:0] nc;
  logic [NR-1:0] acken;
  logic [NR-1:0] and_m;
  logic [NR-1:0] map [NA];
  logic [15:0] trip_t [NA];
  logic [15:0] rst_t [NA];

  // tick divider: one pulse per tick period
  logic [31:0] div;
  logic tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div <= 32'h00000000;
    else if (div == TICK_LIM) div <= 32'h00000000;
    else div <= div + 32'h00000001;
  end
  assign tick = (div == TICK_LIM);

  // pin synchronisers: a change counts once stages two and three agree
  logic [2:0] s1, s2, s3, clean, clean_d;
  wire logic [2:0] pins;
  assign pins = {~toggle_btn_n, remote_in, ~ack_btn_n};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
      clean <= 3'h0;
      clean_d <= 3'h0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      clean <= ((s2 ^ s3) & clean) | (~(s2 ^ s3) & s2);
      clean_d <= clean;
    end
  end
  wire logic [2:0] press;
  wire logic ack_press;
  wire logic toggle_press;
  assign press = clean & ~clean_d;
  assign ack_press = press[0] | (press[1] & ctrl[arl_pkg::F_REM]);
  assign toggle_press = press[2];

  // per-alarm clear band and delays
  logic [NA-1:0] cond;
  logic [NA-1:0] act;
  for (genvar a = 0; a < NA; a++) begin : g_alm
    arl_alarm_unit u_alm (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .enter(alarm_enter[a]),
      .leave(alarm_leave[a]),
      .trip_lim(trip_t[a]),
      .rst_lim(rst_t[a]),
      .cond(cond[a]),
      .act(act[a])
    );
  end

  // combine assigned alarms per relay; AND needs at least one assigned
  logic [NR-1:0] demand;
  logic [NA-1:0] col [NR];
  for (genvar r = 0; r < NR; r++) begin : g_rly
    for (genvar a = 0; a < NA; a++) begin : g_col
      assign col[r][a] = map[a][r];
    end
    assign demand[r] = and_m[r] ? ((|col[r]) && ((act & col[r]) == col[r]))
                                : (|(act & col[r]));
  end

  // latch, latch acknowledge and acknowledge-release flags
  logic [NR-1:0] latched, acked, sup;
  wire logic [NR-1:0] on;
  assign on = ((latch_en & latched) | demand) & ~sup;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= '0;
      acked <= '0;
      sup <= '0;
      relay_drive <= '0;
    end else begin
      latched <= latch_en & (demand | (latched & ~acked));
      acked <= latched & (acked | {NR{ack_press}});
      sup <= demand & (sup | ({NR{ack_press}} & acken));
      relay_drive <= on ^ nc;
    end
  end

  // annunciators: fast flash in alarm, slow after unacked exit of an alarm mapped to a latching relay, steady once acked
  logic [3:0] ph;
  logic [NA-1:0] ann_ack, pend, cond_d;
  logic [NA-1:0] lat_a;
  for (genvar a = 0; a < NA; a++) begin : g_lat
    assign lat_a[a] = |(map[a] & latch_en);
  end
  wire logic fast;
  wire logic slow;
  wire logic [NA-1:0] led;
  assign fast = ph[1];
  assign slow = (ph[3:2] == 2'h3); // longer off time
  assign led = (cond & ann_ack) | (cond & ~ann_ack & {NA{fast}})
             | (~cond & pend & {NA{slow}});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 4'h0;
      ann_ack <= '0;
      pend <= '0;
      cond_d <= '0;
      annunciator <= '0;
    end else begin
      if (tick) ph <= ph + 4'h1;
      cond_d <= cond;
      ann_ack <= cond & (ann_ack | {NA{ack_press}});
      pend <= ~cond & ~{NA{ack_press}}
            & (pend | (cond_d & ~ann_ack & lat_a));
      annunciator <= led;
    end
  end

  // display select; following the default covers power-up and the rate-only and total-only modes
  wire logic [1:0] mode;
  wire logic dflt_total;
  wire logic off_dflt;
  logic [8:0] ret_cnt, msg_cnt;
  assign mode = ctrl[arl_pkg::F_MODE +: 2];
  assign dflt_total = (mode == arl_pkg::MODE_TOTAL)
                    | ((mode == arl_pkg::MODE_BOTH) & ctrl[arl_pkg::F_DFLT]);
  assign off_dflt = show_total ^ dflt_total;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_total <= 1'b0;
      ret_cnt <= 9'h000;
    end else if (mode == arl_pkg::MODE_BOTH && toggle_press) begin
      show_total <= ~show_total;
      ret_cnt <= 9'h000;
    end else if (!off_dflt || mode != arl_pkg::MODE_BOTH) begin
      show_total <= dflt_total;
      ret_cnt <= 9'h000;
    end else if (tick) begin
      if (ret_cnt == RET_LIM) show_total <= dflt_total;
      ret_cnt <= (ret_cnt == RET_LIM) ? 9'h000 : ret_cnt + 9'h001;
    end
  end

  // identifying message pulse while the alternate display is shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_cnt <= 9'h000;
      msg_flash <= 1'b0;
      dec_places <= 3'h0;
    end else begin
      if (!off_dflt) msg_cnt <= 9'h000;
      else if (tick) msg_cnt <= (msg_cnt == MSG_LIM) ? 9'h000 : msg_cnt + 9'h001;
      msg_flash <= off_dflt && (msg_cnt < MSG_ON);
      dec_places <= (ctrl[arl_pkg::F_DEC +: 3] > DEC_MAX) ? DEC_MAX
                                                          : ctrl[arl_pkg::F_DEC +: 3];
    end
  end

  // apb decode; one wait state, pready and data registered
  wire logic [2:0] grp;
  wire logic [2:0] idx;
  wire logic grp_hit;
  wire logic mapped;
  wire logic acc;
  wire logic wr;
  assign grp = paddr[7:5];
  assign idx = paddr[4:2];
  assign grp_hit = (grp == arl_pkg::G_MAP) | (grp == arl_pkg::G_TRIP)
                 | (grp == arl_pkg::G_RST);
  assign mapped = (paddr[1:0] == 2'h0) & (grp_hit | (paddr <= arl_pkg::A_DISP))
                & (!grp_hit || 32'(idx) < NA);
  assign acc = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite & ~pslverr;

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h00000000;
    if (grp == arl_pkg::G_MAP) rdata[NR-1:0] = map[idx];
    else if (grp == arl_pkg::G_TRIP) rdata[15:0] = trip_t[idx];
    else if (grp == arl_pkg::G_RST) rdata[15:0] = rst_t[idx];
    else begin
      unique case (paddr)
        arl_pkg::A_CTRL: rdata[arl_pkg::CTRL_W-1:0] = ctrl;
        arl_pkg::A_LATCH: rdata[NR-1:0] = latch_en;
        arl_pkg::A_NC: rdata[NR-1:0] = nc;
        arl_pkg::A_ACKEN: rdata[NR-1:0] = acken;
        arl_pkg::A_AND: rdata[NR-1:0] = and_m;
        arl_pkg::A_STAT: rdata = 32'({cond, act, {(8 - NR){1'b0}}, on}
                                     & {NA + NA + 8{1'b1}});
        arl_pkg::A_DISP: rdata[1:0] = {msg_flash, show_total};
        default: rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc & ~pwrite & mapped) ? rdata : 32'h00000000;
    end
  end

  // register writes; reset gives OR combining and auto operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= arl_pkg::RST_CTRL;
      latch_en <= '0;
      nc <= '0;
      acken <= '0;
      and_m <= '0;
      for (int a = 0; a < NA; a++) begin
        map[a] <= '0;
        trip_t[a] <= 16'h0000;
        rst_t[a] <= 16'h0000;
      end
    end else if (wr) begin
      if (grp == arl_pkg::G_MAP) map[idx] <= pwdata[NR-1:0];
      else if (grp == arl_pkg::G_TRIP) trip_t[idx] <= pwdata[15:0];
      else if (grp == arl_pkg::G_RST) rst_t[idx] <= pwdata[15:0];
      else if (paddr == arl_pkg::A_CTRL) ctrl <= pwdata[arl_pkg::CTRL_W-1:0];
      else if (paddr == arl_pkg::A_LATCH) latch_en <= pwdata[NR-1:0];
      else if (paddr == arl_pkg::A_NC) nc <= pwdata[NR-1:0];
      else if (paddr == arl_pkg::A_ACKEN) acken <= pwdata[NR-1:0];
      else if (paddr == arl_pkg::A_AND) and_m <= pwdata[NR-1:0];
    end
  end

  // checks on relay 0 and alarm 0, plus the decimals clamp and display return
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ack_hit;
    ack_press && acken[0] && demand[0];
  endsequence
  property p_ack_rel;
    s_ack_hit |=> ##1 (relay_drive[0] == $past(nc[0]));
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack did not release");
  property p_auto;
    !latch_en[0] && !demand[0] |=> (relay_drive[0] == $past(nc[0]));
  endproperty
  a_auto: assert property (p_auto) else $error("auto relay held");
  property p_or;
    !and_m[0] && (|(act & col[0])) && !sup[0] |=> (relay_drive[0] != $past(nc[0]));
  endproperty
  a_or: assert property (p_or) else $error("OR relay not active");
  property p_and;
    and_m[0] && !latch_en[0] && ((act & col[0]) != col[0]) |=> relay_drive[0] == $past(nc[0]);
  endproperty
  a_and: assert property (p_and) else $error("AND relay active early");
  property p_hold;
    latch_en[0] && latched[0] && !acked[0] && !sup[0] |=> relay_drive[0] != $past(nc[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("latched relay dropped");
  property p_dec;
    dec_places <= DEC_MAX;
  endproperty
  a_dec: assert property (p_dec) else $error("too many decimals");
  property p_steady;
    cond[0] && ann_ack[0] |=> annunciator[0];
  endproperty
  a_steady: assert property (p_steady) else $error("acked lamp not steady");
  property p_ret;
    off_dflt && tick && ret_cnt == RET_LIM && !toggle_press |=> !off_dflt;
  endproperty
  a_ret: assert property (p_ret) else $error("no return to default");
endmodule : arl_relay_ctrl
`default_nettype wire

/* File: arl_panel_model.sv */
// arl_panel_model: operator buttons and remote contact facing the relay block
`timescale 1ns/10ps
`default_nettype none
module arl_panel_model (
  // clock
  input wire logic pclk,
  // operator pins
  output var logic ack_btn_n,
  output var logic toggle_btn_n,
  output var logic remote_in
);
  // buttons rest released; pull-ups hold active-low pins high
  initial begin
    ack_btn_n = 1'b1;
    toggle_btn_n = 1'b1;
    remote_in = 1'b0;
  end

  // press one source: 0 front acknowledge, 1 display toggle, 2 remote input
  // held several edges so the three-flop synchroniser sees a clean press
  task press(input int k, input int hold);
    @(posedge pclk);
    case (k)
      0: ack_btn_n <= 1'b0;
      1: toggle_btn_n <= 1'b0;
      default: remote_in <= 1'b1;
    endcase
    repeat (hold) @(posedge pclk);
    ack_btn_n <= 1'b1;
    toggle_btn_n <= 1'b1;
    remote_in <= 1'b0;
  endtask : press
endmodule : arl_panel_model
`default_nettype wire

/* File: arl_relay_ctrl_tb.sv */
// arl_relay_ctrl_tb: self-checking bench of the alarm relay block
`timescale 1ns/10ps
`default_nettype none
module arl_relay_ctrl_tb;
  // clock, reset and apb
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // alarm flags, pins and outputs
  logic [7:0] ae = 8'h00;
  logic [7:0] al = 8'hFF;
  wire logic ack_btn_n;
  wire logic remote_in;
  wire logic toggle_btn_n;
  logic [6:0] relay_drive;
  logic [7:0] annunciator;
  logic show_total;
  logic msg_flash;
  logic [2:0] dec_places;
  // bench state and reference model
  int n_fail = 0;
  int checks = 0;
  logic [31:0] seed = 32'h0000_9223;
  int m_map [8];
  int m_and;
  int m_nc;
  int n;
  int c1;
  int c2;
  logic [31:0] rd;
  logic er;

  // short tick so delays and the display timers fit the run
  arl_relay_ctrl #(.NA(8), .NR(7), .DIGITS(5), .TICK_CYC(10)) u_arl_relay_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_enter(ae), .alarm_leave(al), .ack_btn_n(ack_btn_n), .remote_in(remote_in),
    .toggle_btn_n(toggle_btn_n), .relay_drive(relay_drive), .annunciator(annunciator),
    .show_total(show_total), .msg_flash(msg_flash), .dec_places(dec_places));
  arl_panel_model u_arl_panel_model (.pclk(pclk), .ack_btn_n(ack_btn_n),
    .toggle_btn_n(toggle_btn_n), .remote_in(remote_in));

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // one apb transfer; waits for pready, never assumes a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // enter/leave are complementary so cleared alarms pass the clear band
  task alarm(input logic [7:0] p);
    @(posedge pclk);
    ae <= p;
    al <= ~p;
  endtask : alarm

  task count_led(output int c);
    c = 0;
    repeat (160) begin
      @(posedge pclk);
      c += int'(annunciator[0] === 1'b1);
    end
  endtask : count_led

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // reference: or/and of assigned alarms, then polarity
  function automatic logic [6:0] exp_relay(input logic [7:0] p);
    logic [6:0] r;
    int sel;
    for (int j = 0; j < 7; j++) begin
      sel = 0;
      for (int i = 0; i < 8; i++) begin
        sel |= ((m_map[i] >> j) & 1) << i;
      end
      r[j] = m_and[j] ? (sel != 0 && (p & sel) == sel) : ((p & sel) != 0);
    end
    return r ^ m_nc[6:0];
  endfunction : exp_relay

  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(relay_drive), 32'h0);
    chk(32'(show_total), 32'h0);
    apb(1'b0, arl_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, arl_pkg::A_AND, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, arl_pkg::A_LATCH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk(32'(er), 32'h1);
    // random maps, combining and polarity against the model
    m_and = xs() & 32'h7F;
    m_nc = xs() & 32'h7F;
    apb(1'b1, arl_pkg::A_AND, m_and);
    apb(1'b1, arl_pkg::A_NC, m_nc);
    apb(1'b0, arl_pkg::A_AND, 32'h0);
    chk(rd, 32'(m_and));
    for (int i = 0; i < 8; i++) begin
      m_map[i] = xs() & 32'h7F;
      apb(1'b1, {arl_pkg::G_MAP, 3'(i), 2'h0}, m_map[i]);
    end
    repeat (4) @(posedge pclk);
    chk(32'(relay_drive), 32'(m_nc[6:0]));
    for (int k = 0; k < 12; k++) begin
      c1 = (k == 0) ? 32'hFF : (k == 1) ? 32'h0 : xs() & 32'hFF;
      alarm(c1[7:0]);
      repeat (8) @(posedge pclk);
      chk(32'(relay_drive), 32'(exp_relay(c1[7:0])));
    end
    // latching relay 0 on alarm 0, acknowledge-enabled relay 1, delayed relay 2
    alarm(8'h00);
    apb(1'b1, arl_pkg::A_NC, 32'h0);
    apb(1'b1, arl_pkg::A_AND, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, {arl_pkg::G_MAP, 3'(i), 2'h0}, (i < 3) ? (1 << i) : 0);
    end
    apb(1'b1, arl_pkg::A_LATCH, 32'h1);
    apb(1'b1, arl_pkg::A_ACKEN, 32'h2);
    alarm(8'h01);
    repeat (8) @(posedge pclk);
    chk(32'(relay_drive[0]), 32'h1);
    count_led(c1);
    alarm(8'h00);
    repeat (8) @(posedge pclk);
    chk(32'(relay_drive[0]), 32'h1);
    count_led(c2);
    chk(32'(c1 > c2 && c2 > 0 && c1 < 160), 32'h1);
    u_arl_panel_model.press(0, 6);
    repeat (16) @(posedge pclk);
    chk(32'(relay_drive[0]), 32'h0);
    chk(32'(annunciator[0]), 32'h0);
    alarm(8'h01);
    repeat (8) @(posedge pclk);
    u_arl_panel_model.press(0, 6);
    repeat (16) @(posedge pclk);
    count_led(c1);
    chk(32'(c1), 32'd160);
    chk(32'(relay_drive[0]), 32'h1);
    alarm(8'h00);
    repeat (8) @(posedge pclk);
    chk(32'(relay_drive[0]), 32'h0);
    // acknowledge in alarm, front button then remote input
    alarm(8'h02);
    repeat (2) @(posedge pclk);
    ae <= 8'h00;
    al <= 8'h00;
    repeat (8) @(posedge pclk);
    chk(32'(relay_drive[1]), 32'h1);
    u_arl_panel_model.press(0, 6);
    repeat (16) @(posedge pclk);
    chk(32'(relay_drive[1]), 32'h0);
    alarm(8'h00);
    repeat (4) @(posedge pclk);
    alarm(8'h02);
    repeat (8) @(posedge pclk);
    u_arl_panel_model.press(2, 6);
    repeat (16) @(posedge pclk);
    chk(32'(relay_drive[1]), 32'h1);
    apb(1'b1, arl_pkg::A_CTRL, 32'h100);
    u_arl_panel_model.press(2, 6);
    repeat (16) @(posedge pclk);
    chk(32'(relay_drive[1]), 32'h0);
    alarm(8'h00);
    // acknowledge-enabled latching relay releases while still in alarm
    apb(1'b1, arl_pkg::A_ACKEN, 32'h3);
    alarm(8'h01);
    repeat (8) @(posedge pclk);
    chk(32'(relay_drive[0]), 32'h1);
    u_arl_panel_model.press(0, 6);
    repeat (16) @(posedge pclk);
    chk(32'(relay_drive[0]), 32'h0);
    alarm(8'h00);
    // trip and reset delays of 4 ticks, restarted by a drop-out
    apb(1'b1, {arl_pkg::G_TRIP, 3'h2, 2'h0}, 32'h4);
    apb(1'b1, {arl_pkg::G_RST, 3'h2, 2'h0}, 32'h4);
    alarm(8'h04);
    repeat (20) @(posedge pclk);
    alarm(8'h00);
    alarm(8'h04);
    repeat (25) @(posedge pclk);
    chk(32'(relay_drive[2]), 32'h0);
    n = 0;
    while (relay_drive[2] !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(relay_drive[2]), 32'h1);
    alarm(8'h00);
    repeat (25) @(posedge pclk);
    chk(32'(relay_drive[2]), 32'h1);
    repeat (40) @(posedge pclk);
    chk(32'(relay_drive[2]), 32'h0);
    // display: mode both, decimals clamped, toggle, flash and return
    apb(1'b1, arl_pkg::A_CTRL, 32'h72);
    repeat (2) @(posedge pclk);
    chk(32'(dec_places), 32'h4);
    u_arl_panel_model.press(1, 6);
    repeat (12) @(posedge pclk);
    chk(32'(show_total), 32'h1);
    n = 0;
    while (msg_flash !== 1'b0 && n < 900) begin
      @(posedge pclk);
      n++;
    end
    c1 = n;
    while (msg_flash !== 1'b1 && n < 1800) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(msg_flash), 32'h1);
    chk(32'(n - c1 > 740 && n - c1 < 760), 32'h1);
    while (show_total !== 1'b0 && n < 3300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n > 2900 && n < 3100), 32'h1);
    apb(1'b1, arl_pkg::A_CTRL, 32'h30);
    u_arl_panel_model.press(1, 6);
    repeat (12) @(posedge pclk);
    chk(32'(show_total), 32'h0);
    chk(32'(dec_places), 32'h3);
    // total-only mode, then both with total as the default display
    apb(1'b1, arl_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(show_total), 32'h1);
    apb(1'b1, arl_pkg::A_CTRL, 32'h6);
    repeat (2) @(posedge pclk);
    chk(32'(show_total), 32'h1);
    u_arl_panel_model.press(1, 6);
    repeat (12) @(posedge pclk);
    chk(32'(show_total), 32'h0);
    // reset in mid-run with closed relays
    apb(1'b1, arl_pkg::A_NC, 32'h7F);
    repeat (4) @(posedge pclk);
    chk(32'(relay_drive), 32'h7F);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(relay_drive), 32'h0);
    chk(32'(show_total), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, arl_pkg::A_NC, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : arl_relay_ctrl_tb
`default_nettype wire
